// file: rtl/lprs_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module lprs_supervisor
    import lprs_pkg::*;
#(
    parameter int               VARIANT       = VAR_SINGLE, // R12
    parameter bit               HAS_MONITOR   = 1'h0,
    parameter logic [CNT_W-1:0] SETUP_LIM     = CNT_W'(SETUP_CYCLES), // R12
    parameter logic [CNT_W-1:0] TIMEOUT_LIM   = CNT_W'(TIMEOUT_CYCLES),
    parameter logic [CNT_W-1:0] DEBOUNCE_LIM  = CNT_W'(DEBOUNCE_CYCLES)
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic supply_ok,
    input  wire logic adjustable_monitor_in,
    input  wire logic long_press_reset_in,
    input  wire logic second_manual_reset_in,
    output var  logic reset_out_n
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] pins;

    assign pins = {supply_ok, adjustable_monitor_in, long_press_reset_in, second_manual_reset_in};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 4'hF;
            s2_r <= 4'hF;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end

    logic sup_ok;
    logic mr1_low;
    logic mr2_lvl;
    logic press_now;

    assign sup_ok    = s2_r[3] && (!HAS_MONITOR || s2_r[2]); // R07
    assign mr1_low   = !s2_r[1];
    assign mr2_lvl   = s2_r[0];
    // R03
    assign press_now = (VARIANT == VAR_DUAL) ? (mr1_low && !mr2_lvl) : mr1_low;

    // ------------------------------------------------------------------
    // long-press detector
    // ------------------------------------------------------------------
    lprs_press_t press_r;
    lprs_press_t press_nxt;
    logic        setup_done;
    logic        lp_fire;

    lprs_timer u_setup (
        .clk   (clk),
        .rst   (rst),
        .clear (1'h0),
        .run   (press_now && press_r == LPRS_HOLD),
        .limit (SETUP_LIM),
        .done  (setup_done)
    );

    always_comb begin
        press_nxt = press_r;
        lp_fire   = 1'h0;
        case (press_r)
            LPRS_IDLE: begin
                if (press_now) begin
                    press_nxt = LPRS_HOLD;
                end
            end
            LPRS_HOLD: begin
                if (!press_now) begin
                    press_nxt = LPRS_IDLE; // R02
                end else if (setup_done) begin
                    press_nxt = LPRS_FIRED;
                    lp_fire   = 1'h1; // R01
                end
            end
            LPRS_FIRED: begin
                if (!press_now) begin
                    press_nxt = LPRS_IDLE; // R10
                end
            end
            default: press_nxt = LPRS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            press_r <= LPRS_IDLE;
        end else begin
            press_r <= press_nxt;
        end
    end

    // ------------------------------------------------------------------
    // immediate input: rising edge fires, falling edge debounced
    // ------------------------------------------------------------------
    logic imm_r;
    logic imm_nxt;
    logic deb_done;
    logic imm_fire;

    lprs_timer u_deb (
        .clk   (clk),
        .rst   (rst),
        .clear (1'h0),
        .run   (imm_r && !mr2_lvl),
        .limit (DEBOUNCE_LIM),
        .done  (deb_done)
    );

    always_comb begin
        imm_nxt  = imm_r;
        imm_fire = 1'h0;
        if (VARIANT == VAR_IMMEDIATE) begin
            if (!imm_r && mr2_lvl) begin
                imm_nxt  = 1'h1;
                imm_fire = 1'h1; // R04
            end else if (imm_r && deb_done) begin
                imm_nxt = 1'h0; // R05
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imm_r <= 1'h1;
        end else begin
            imm_r <= imm_nxt;
        end
    end

    // ------------------------------------------------------------------
    // reset output timing
    // ------------------------------------------------------------------
    logic rst_out_r;
    logic rst_out_nxt;
    logic tmo_done;
    logic trig;

    assign trig = lp_fire || imm_fire || !sup_ok;

    lprs_timer u_tmo (
        .clk   (clk),
        .rst   (rst),
        .clear (trig), // R08 R09
        .run   (rst_out_r == RESET_LVL_R),
        .limit (TIMEOUT_LIM), // R06
        .done  (tmo_done)
    );

    always_comb begin
        rst_out_nxt = rst_out_r;
        if (trig) begin
            rst_out_nxt = RESET_LVL_R; // R01 R04 R08
        end else if (tmo_done) begin
            rst_out_nxt = !RESET_LVL_R;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_out_r <= RESET_LVL_R;
        end else begin
            rst_out_r <= rst_out_nxt;
        end
    end

    assign reset_out_n = rst_out_r;

    // ------------------------------------------------------------------
    // check helper: cycles since the last reset trigger
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] since_trig_r;
    logic [CNT_W-1:0] since_trig_nxt;

    always_comb begin
        since_trig_nxt = since_trig_r;
        if (trig) begin
            since_trig_nxt = '0;
        end else if (since_trig_r != '1) begin
            since_trig_nxt = since_trig_r + 1'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_trig_r <= '0;
        end else begin
            since_trig_r <= since_trig_nxt;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_supply_holds: assert property (@(posedge clk) disable iff (rst) // R08
        !sup_ok |=> !reset_out_n) else $error("reset released during supply fail");
    a_fire_asserts: assert property (@(posedge clk) disable iff (rst) // R01
        lp_fire |=> !reset_out_n) else $error("long press did not assert reset");
    a_short_quiet: assert property (@(posedge clk) disable iff (rst) // R02
        (press_r == LPRS_HOLD && !press_now) |-> !lp_fire) else $error("short press fired");
    a_dual_both: assert property (@(posedge clk) disable iff (rst) // R03
        (VARIANT == VAR_DUAL && lp_fire) |-> (mr1_low && !mr2_lvl)) else $error("dual fired on one input");
    a_imm_edge: assert property (@(posedge clk) disable iff (rst) // R04
        (VARIANT == VAR_IMMEDIATE && !imm_r && mr2_lvl) |=> !reset_out_n) else $error("edge missed");
    a_fire_once: assert property (@(posedge clk) disable iff (rst) // R10
        lp_fire |=> !lp_fire) else $error("second pulse in one press");
    a_release_time: assert property (@(posedge clk) disable iff (rst) // R06 R08
        $rose(reset_out_n) |-> (since_trig_r == TIMEOUT_LIM + 1'h1)) else $error("release off timeout");
    a_mon_fail: assert property (@(posedge clk) disable iff (rst) // R07
        (HAS_MONITOR && !s2_r[2]) |=> !reset_out_n) else $error("monitor fail ignored");
    a_restart: assert property (@(posedge clk) disable iff (rst) // R09
        imm_fire |=> !tmo_done) else $error("timeout not restarted");

    c_long_press: cover property (@(posedge clk) disable iff (rst) lp_fire);
    c_imm_press: cover property (@(posedge clk) disable iff (rst) imm_fire);
    c_release: cover property (@(posedge clk) disable iff (rst) $rose(reset_out_n));
    c_supply_fail: cover property (@(posedge clk) disable iff (rst) !sup_ok);
    c_restart: cover property (@(posedge clk) disable iff (rst) imm_fire && !reset_out_n);

endmodule
`default_nettype wire

// file: rtl/lprs_pkg.sv
// Behaviour
// R01 - long-press input low for full setup period gives one reset pulse of timeout length
// R02 - presses shorter than setup period leave reset output released
// R03 - dual-input variant pulses only after both inputs held low full setup period
// R04 - immediate input rising edge at once starts low reset pulse of timeout length
// R05 - immediate input falling edge debounced so release gives no false reset
// R06 - one timeout period times manual and supply-triggered reset pulses alike
// R07 - adjustable monitor below threshold counts as a supply fail
// R08 - reset held while any supply fails, released one timeout after all recover
// R09 - new immediate rising edge during timeout restarts the timeout counter
// R10 - one pulse per long press; an input must release before another pulse
// R11 - outside party holds both long-press inputs low together for the setup period
// R12 - intervals come from clock counts as parameters; variant chosen by parameters
package lprs_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ          = 10000000;
    localparam longint SETUP_MS        = 6720;
    localparam longint TIMEOUT_MS      = 210;
    localparam longint DEBOUNCE_MS     = 210;
    localparam longint SETUP_CYCLES    = SETUP_MS * CLK_HZ / 1000;
    localparam longint TIMEOUT_CYCLES  = TIMEOUT_MS * CLK_HZ / 1000;
    localparam longint DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_HZ / 1000;

    localparam int CNT_W = 27;

    // ------------------------------------------------------------------
    // variants
    // ------------------------------------------------------------------
    localparam int VAR_SINGLE    = 0;
    localparam int VAR_DUAL      = 1;
    localparam int VAR_IMMEDIATE = 2;

    localparam logic RESET_LVL_R = 1'h0;

    typedef enum logic [1:0] {
        LPRS_IDLE  = 2'b00,
        LPRS_HOLD  = 2'b01,
        LPRS_FIRED = 2'b10
    } lprs_press_t;

endpackage

// file: rtl/lprs_timer.sv
`timescale 1ns/1ns
`default_nettype none
module lprs_timer
    import lprs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] limit,
    output var  logic             done
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // ------------------------------------------------------------------
    // saturating counter, done once limit reached
    // ------------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        if (clear || !run) begin
            cnt_nxt = '0;
        end else if (cnt_r < limit) begin
            cnt_nxt = cnt_r + 1'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done = run && !clear && (cnt_r >= limit);

endmodule
`default_nettype wire

// file: tb/lprs_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// processor reset input: counts low pulses
// and keeps the width of the last one
// ----------------------------------------
module lprs_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        reset_in_n,
    output var  logic [31:0] pulses,
    output var  logic [31:0] width
);
    logic [31:0] run_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulses <= 32'h0;
            width  <= 32'h0;
            run_r  <= 32'h0;
        end else if (reset_in_n !== 1'h1) begin
            run_r <= run_r + 32'h1;
        end else if (run_r != 32'h0) begin
            pulses <= pulses + 32'h1;
            width  <= run_r;
            run_r  <= 32'h0;
        end
    end
endmodule
`default_nettype wire

// file: tb/lprs_supervisor_test.sv
`timescale 1ns/1ns
`default_nettype none
module lprs_supervisor_test;
    import lprs_pkg::*;
    localparam int S = 40;
    localparam int T = 30;
    localparam int D = 15;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        sup = 1'h1;
    logic        mon = 1'h1;
    logic        lp  = 1'h1;
    logic        imm = 1'h0;
    logic        lp2 = 1'h1;
    logic        rn;
    logic        rn2;
    logic [31:0] pulses, width, p0;
    logic [31:0] pulses2, width2, q0;
    int          mismatches = 0;
    int          num_checks = 0;
    always #50 clk = ~clk;
    lprs_supervisor #(.VARIANT(VAR_IMMEDIATE), .HAS_MONITOR(1'b1), .SETUP_LIM(CNT_W'(S)),
        .TIMEOUT_LIM(CNT_W'(T)), .DEBOUNCE_LIM(CNT_W'(D))) u_lprs_supervisor (
        .clk(clk), .rst(rst), .supply_ok(sup), .adjustable_monitor_in(mon),
        .long_press_reset_in(lp), .second_manual_reset_in(imm), .reset_out_n(rn));
    lprs_cpu_model u_lprs_cpu_model (.clk(clk), .rst(rst), .reset_in_n(rn),
        .pulses(pulses), .width(width));
    // dual long-press variant without the adjustable monitor
    lprs_supervisor #(.VARIANT(VAR_DUAL), .HAS_MONITOR(1'h0), .SETUP_LIM(CNT_W'(S)),
        .TIMEOUT_LIM(CNT_W'(T)), .DEBOUNCE_LIM(CNT_W'(D))) u_lprs_supervisor_dual (
        .clk(clk), .rst(rst), .supply_ok(sup), .adjustable_monitor_in(mon),
        .long_press_reset_in(lp), .second_manual_reset_in(lp2), .reset_out_n(rn2));
    lprs_cpu_model u_lprs_cpu_model_dual (.clk(clk), .rst(rst), .reset_in_n(rn2),
        .pulses(pulses2), .width(width2));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t: level %b expected %b", $time, got, exp);
        end
    endtask
    task chk_rng(input logic [31:0] got, input int lo, input int hi);
        num_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            mismatches++;
            $display("BAD %0t: value %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task wait_high;
        for (int i = 0; i < 300 && rn !== 1'h1; i++) @(negedge clk);
        if (rn !== 1'h1) begin
            mismatches++;
            $display("BAD %0t: reset output stuck low", $time);
            give_verdict;
        end
        cyc(2);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_short;
        p0 = pulses;
        lp = 1'h0;
        cyc(S - 10);
        lp = 1'h1;
        cyc(3);
        lp = 1'h0;
        cyc(S - 10);
        lp = 1'h1;
        cyc(S);
        chk_rng(pulses, p0, p0);
        $display("short presses done");
    endtask
    task t_long;
        p0 = pulses;
        lp = 1'h0;
        cyc(3 * S);
        chk_rng(pulses, p0 + 1, p0 + 1);
        chk_rng(width, T + 1, T + 4);
        lp = 1'h1;
        cyc(10);
        lp = 1'h0;
        cyc(S + 8);
        chk_bit(rn, 1'h0);
        lp = 1'h1;
        wait_high;
        $display("long press done");
    endtask
    task t_imm;
        p0 = pulses;
        imm = 1'h1;
        cyc(5);
        chk_bit(rn, 1'h0);
        imm = 1'h0;
        cyc(D + 3);
        imm = 1'h1;
        cyc(T - 5);
        chk_bit(rn, 1'h0);
        wait_high;
        chk_rng(pulses, p0 + 1, p0 + 1);
        chk_rng(width, 23 + T, 28 + T);
        imm = 1'h0;
        cyc(5);
        imm = 1'h1;
        cyc(5);
        imm = 1'h0;
        cyc(3 * T);
        chk_rng(pulses, p0 + 1, p0 + 1);
        $display("immediate input done");
    endtask
    task t_dual;
        q0 = pulses2;
        lp2 = 1'h0;
        cyc(2 * S);
        chk_rng(pulses2, q0, q0);
        lp = 1'h0;
        cyc(S - 10);
        lp2 = 1'h1;
        cyc(3);
        lp2 = 1'h0;
        cyc(S - 10);
        chk_bit(rn2, 1'h1);
        cyc(20);
        chk_bit(rn2, 1'h0);
        cyc(40);
        chk_rng(pulses2, q0 + 1, q0 + 1);
        chk_rng(width2, T + 1, T + 4);
        lp = 1'h1;
        lp2 = 1'h1;
        wait_high;
        $display("dual press done");
    endtask
    task t_supply;
        for (int i = 0; i < 2; i++) begin
            p0 = pulses;
            if (i == 0) sup = 1'h0;
            else mon = 1'h0;
            cyc(4);
            chk_bit(rn, 1'h0);
            chk_bit(rn2, i[0]);
            cyc(6);
            sup = 1'h1;
            mon = 1'h1;
            wait_high;
            chk_rng(width, 10 + T, 16 + T);
        end
        $display("supply fail done");
    endtask
    initial begin
        cyc(8);
        chk_bit(rn, 1'h0);
        chk_bit(rn2, 1'h0);
        rst = 1'h0;
        wait_high;
        t_short;
        t_long;
        t_imm;
        t_dual;
        t_supply;
        give_verdict;
    end
endmodule
`default_nettype wire
